// ---- hdl/psr_pkg.sv ----
// Package for the port status and reset register bank
package psr_pkg;
    // ------------------------------------------------------------------
    // Register indices; the byte address on the bus is index*4
    // ------------------------------------------------------------------
    localparam logic [7:0] PSR_IDX_P1_STATUS_B  = 8'h1F;
    localparam logic [7:0] PSR_IDX_P2_STATUS_B  = 8'h2F;
    localparam logic [7:0] PSR_IDX_P3_STATUS_B  = 8'h3F;
    localparam logic [7:0] PSR_IDX_P1_STATUS_A  = 8'h1E;
    localparam logic [7:0] PSR_IDX_P2_STATUS_A  = 8'h2E;
    localparam logic [7:0] PSR_IDX_RESET_CTRL   = 8'h43;
    localparam int         PSR_ADDR_W           = 10;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PSR_BIT_XOVER    = 7;
    localparam int PSR_BIT_RSVD     = 6;
    localparam int PSR_BIT_POL      = 5;
    localparam int PSR_BIT_TXFC     = 4;
    localparam int PSR_BIT_RXFC     = 3;
    localparam int PSR_BIT_SPEED    = 2;
    localparam int PSR_BIT_DUPLEX   = 1;
    localparam int PSR_BIT_FAULT    = 0;
    localparam int PSR_BIT_AUTONEG_CPL = 6;
    localparam int PSR_BIT_LINKGOOD = 5;
    localparam int PSR_BIT_SWRST    = 4;
    localparam int PSR_BIT_CODRST   = 0;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       PSR_XOVER_RST = 1'b1;
    localparam logic [1:0] PSR_RSTCTL_RST = 2'b00;
endpackage

// ---- hdl/psr_sync.sv ----
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/100ps
`default_nettype none
module psr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Stage chain; the first stage only feeds the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Per bit, accept a change only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/psr_regs.sv ----
// Port link status and global reset register bank, Avalon-MM slave
//
// Summary of operation
// - Status register B of ports 1,2,3 at 0x1F, 0x2F, 0x3F, same layout.
// - Bit 7 selects crossover scheme, 1 first scheme; default 1; PHY ports only.
// - Bit 6 reserved, reads 0; software leaves it at default.
// - Bit 5 reads reversed receive polarity, 10BT only, not port 3.
// - Bit 4 reads 1 while transmit pause flow control is active.
// - Bit 3 reads 1 while receive pause flow control is active.
// - Bit 2 reads link speed: 1 is 100 Mbps, 0 is 10 Mbps.
// - Bit 1 reads link duplex: 1 full, 0 half.
// - Bit 0 reads remote fault detected, port 1 only.
// - Reset control register at 0x43, bits 4 and 0, both default 0.
// - Bit 4 set returns all registers to reset values except bit 0 here, straps kept.
// - Bit 0 set resets the coding layer state machines and clock domain.
// - Status register A of ports 1,2: autoneg complete bit 6, link good bit 5.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module psr_regs
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Avalon-MM slave
    input  wire logic [PSR_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic [1:0]                 avs_response,
    // Live link state per port, index 0 is port 1
    input  wire logic [2:0]            link_pol_reversed,
    input  wire logic [2:0]            link_tx_pause,
    input  wire logic [2:0]            link_rx_pause,
    input  wire logic [2:0]            link_speed_100,
    input  wire logic [2:0]            link_full_duplex,
    input  wire logic [2:0]            link_remote_fault,
    input  wire logic [1:0]            autoneg_complete,
    input  wire logic [1:0]            link_good,
    // Controls toward the PHYs
    output logic      [1:0]            crossover_scheme_select,
    output logic                       coding_layer_reset,
    output logic                       soft_reset_pulse
);
    // ------------------------------------------------------------------
    // Slave handshake states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSR_IDLE = 2'b00,
        PSR_ACK  = 2'b01,
        PSR_REL  = 2'b11
    } psr_state_t;

    // Bit positions inside the synchronised live-state vector
    localparam int LV_POL   = 0;
    localparam int LV_TXFC  = 3;
    localparam int LV_RXFC  = 6;
    localparam int LV_SPEED = 9;
    localparam int LV_DUPLX = 12;
    localparam int LV_FAULT = 15;
    localparam int LV_AN    = 18;
    localparam int LV_LINK  = 20;
    localparam int NSYNC    = 22;

    psr_state_t  state_r;
    logic [NSYNC-1:0] live_raw;
    logic [NSYNC-1:0] live;
    logic [1:0]  xover_r;
    logic        swrst_r;
    logic        codrst_r;
    logic        soft_clr;
    logic [7:0]  idx;
    logic        wr_hit;
    logic [7:0]  rd_byte;
    logic        rd_ok;

    // ------------------------------------------------------------------
    // Pin synchronisers: all status arrives from other clock domains
    // ------------------------------------------------------------------
    assign live_raw = {link_good, autoneg_complete, link_remote_fault,
                       link_full_duplex, link_speed_100, link_rx_pause,
                       link_tx_pause, link_pol_reversed};

    psr_sync #(.W(NSYNC)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (live_raw),
        .q      (live)
    );

    // Byte address to register index
    assign idx    = avs_address[PSR_ADDR_W-1:2];
    // A write lands on the edge that also sees waitrequest low, as the master expects
    assign wr_hit = (state_r == PSR_ACK) && avs_write && avs_byteenable[0];
    // Software reset acts one cycle after the write lands
    assign soft_clr = swrst_r;

    // ------------------------------------------------------------------
    // Bus handshake: waitrequest high by default, low one cycle to ack
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r         <= PSR_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            unique case (state_r)
                PSR_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_r         <= PSR_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                PSR_ACK: begin
                    state_r         <= PSR_REL;
                    avs_waitrequest <= 1'b1;
                end
                PSR_REL: begin
                    // Gap cycle so a held request is not taken twice
                    state_r <= PSR_IDLE;
                end
                default: begin
                    state_r         <= PSR_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Crossover scheme select, PHY ports only
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn || soft_clr) begin
            xover_r <= {2{PSR_XOVER_RST}};
        end else if (wr_hit) begin
            if (idx == PSR_IDX_P1_STATUS_B) begin
                xover_r[0] <= avs_writedata[PSR_BIT_XOVER];
            end
            if (idx == PSR_IDX_P2_STATUS_B) begin
                xover_r[1] <= avs_writedata[PSR_BIT_XOVER];
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset control register; write of 1 sets, write of 0 clears
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            swrst_r  <= PSR_RSTCTL_RST[1];
            codrst_r <= PSR_RSTCTL_RST[0];
        end else if (soft_clr) begin
            // Self-clearing; the coding-layer request stays until written 0
            swrst_r  <= PSR_RSTCTL_RST[1];
        end else if (wr_hit && idx == PSR_IDX_RESET_CTRL) begin
            swrst_r  <= avs_writedata[PSR_BIT_SWRST];
            codrst_r <= avs_writedata[PSR_BIT_CODRST];
        end
    end

    // Drive control outputs from flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            crossover_scheme_select <= {2{PSR_XOVER_RST}};
            coding_layer_reset      <= 1'b0;
            soft_reset_pulse        <= 1'b0;
        end else begin
            crossover_scheme_select <= xover_r;
            coding_layer_reset      <= codrst_r;
            soft_reset_pulse        <= swrst_r;
        end
    end

    // ------------------------------------------------------------------
    // Read mux; read-only bits come only from live state
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        // Polarity passes through at any speed; it only means something at 10BT
        unique case (idx)
            PSR_IDX_P1_STATUS_B: begin
                rd_byte[PSR_BIT_XOVER]  = xover_r[0];
                rd_byte[PSR_BIT_RSVD]   = 1'b0;
                rd_byte[PSR_BIT_POL]    = live[LV_POL];
                rd_byte[PSR_BIT_TXFC]   = live[LV_TXFC];
                rd_byte[PSR_BIT_RXFC]   = live[LV_RXFC];
                rd_byte[PSR_BIT_SPEED]  = live[LV_SPEED];
                rd_byte[PSR_BIT_DUPLEX] = live[LV_DUPLX];
                rd_byte[PSR_BIT_FAULT]  = live[LV_FAULT];
            end
            PSR_IDX_P2_STATUS_B: begin
                rd_byte[PSR_BIT_XOVER]  = xover_r[1];
                rd_byte[PSR_BIT_RSVD]   = 1'b0;
                rd_byte[PSR_BIT_POL]    = live[LV_POL + 1];
                rd_byte[PSR_BIT_TXFC]   = live[LV_TXFC + 1];
                rd_byte[PSR_BIT_RXFC]   = live[LV_RXFC + 1];
                rd_byte[PSR_BIT_SPEED]  = live[LV_SPEED + 1];
                rd_byte[PSR_BIT_DUPLEX] = live[LV_DUPLX + 1];
                rd_byte[PSR_BIT_FAULT]  = 1'b0;
            end
            PSR_IDX_P3_STATUS_B: begin
                // The MII port has no PHY: scheme, polarity and fault read 0
                rd_byte[PSR_BIT_XOVER]  = 1'b0;
                rd_byte[PSR_BIT_RSVD]   = 1'b0;
                rd_byte[PSR_BIT_POL]    = 1'b0;
                rd_byte[PSR_BIT_TXFC]   = live[LV_TXFC + 2];
                rd_byte[PSR_BIT_RXFC]   = live[LV_RXFC + 2];
                rd_byte[PSR_BIT_SPEED]  = live[LV_SPEED + 2];
                rd_byte[PSR_BIT_DUPLEX] = live[LV_DUPLX + 2];
                rd_byte[PSR_BIT_FAULT]  = 1'b0;
            end
            PSR_IDX_P1_STATUS_A: begin
                rd_byte[PSR_BIT_AUTONEG_CPL] = live[LV_AN];
                rd_byte[PSR_BIT_LINKGOOD]    = live[LV_LINK];
            end
            PSR_IDX_P2_STATUS_A: begin
                rd_byte[PSR_BIT_AUTONEG_CPL] = live[LV_AN + 1];
                rd_byte[PSR_BIT_LINKGOOD]    = live[LV_LINK + 1];
            end
            PSR_IDX_RESET_CTRL: begin
                rd_byte[PSR_BIT_SWRST]  = swrst_r;
                rd_byte[PSR_BIT_CODRST] = codrst_r;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read data registered when the answer is given
    always_ff @(posedge clk) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (state_r == PSR_IDLE && (avs_read || avs_write)) begin
            avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            avs_response <= rd_ok ? 2'b00 : 2'b11;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Reset defaults of the writable fields
    a_xover_default: assert property (
        @(posedge clk) $rose(resetn) |-> xover_r == 2'b11)
        else $error("crossover default wrong");
    a_ctl_default: assert property (
        @(posedge clk) $rose(resetn) |-> !swrst_r && !codrst_r)
        else $error("reset control default wrong");

    // Read data: reserved, upper and not-applicable bits stay zero
    a_rsvd_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest && avs_read && (idx == PSR_IDX_P1_STATUS_B
        || idx == PSR_IDX_P2_STATUS_B || idx == PSR_IDX_P3_STATUS_B)
        |-> avs_readdata[PSR_BIT_RSVD] == 1'b0)
        else $error("reserved bit nonzero");
    a_port3_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest && avs_read && idx == PSR_IDX_P3_STATUS_B |->
        !avs_readdata[PSR_BIT_XOVER] && !avs_readdata[PSR_BIT_POL]
        && !avs_readdata[PSR_BIT_FAULT])
        else $error("port 3 bit not zero");
    a_upper_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read data nonzero");

    // Writable fields take the written value, others ignore writes
    a_scheme_write: assert property (
        @(posedge clk) disable iff (!resetn)
        wr_hit && idx == PSR_IDX_P1_STATUS_B |=>
        xover_r[0] == $past(avs_writedata[PSR_BIT_XOVER]))
        else $error("scheme bit write lost");
    a_ro_ignored: assert property (
        @(posedge clk) disable iff (!resetn)
        wr_hit && idx == PSR_IDX_P3_STATUS_B |=> $stable(xover_r))
        else $error("port 3 write changed state");

    // Software reset restores the fields, clears itself and pulses once
    a_swrst_clear: assert property (
        @(posedge clk) disable iff (!resetn)
        swrst_r |=> !swrst_r && xover_r == 2'b11)
        else $error("soft reset did not restore");
    a_pulse_once: assert property (
        @(posedge clk) disable iff (!resetn)
        swrst_r |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    a_coding_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        coding_layer_reset == $past(codrst_r))
        else $error("coding reset not driven");

    // Handshake: one answer cycle, one cycle after the request is taken
    a_ack_one: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("ack longer than one cycle");
    a_ack_bound: assert property (
        @(posedge clk) disable iff (!resetn)
        state_r == PSR_IDLE && (avs_read || avs_write) |=> !avs_waitrequest)
        else $error("late answer");

    // Main scenarios
    c_read: cover property (@(posedge clk) avs_read && !avs_waitrequest);
    c_write: cover property (@(posedge clk) avs_write && !avs_waitrequest);
    c_swrst: cover property (@(posedge clk) swrst_r);
    c_full_reset: cover property (@(posedge clk) soft_reset_pulse && coding_layer_reset);
endmodule
`default_nettype wire

// ---- verif/psr_regs_test.sv ----
// Self-checking bench for the port status and reset register bank
`timescale 1ns/100ps
`default_nettype none
module psr_regs_test
    import psr_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic                  clk;
    logic                  resetn;
    logic [PSR_ADDR_W-1:0] avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [1:0]            avs_response;
    logic [2:0]            link_pol_reversed, link_tx_pause, link_rx_pause;
    logic [2:0]            link_speed_100, link_full_duplex, link_remote_fault;
    logic [1:0]            autoneg_complete, link_good;
    logic [1:0]            crossover_scheme_select;
    logic                  coding_layer_reset;
    logic                  soft_reset_pulse;
    int                    bad_count, check_count, cyc, pulse_cnt;
    logic [31:0]           d;
    logic [1:0]            r;
    logic [7:0]            idx_b [3] = '{PSR_IDX_P1_STATUS_B, PSR_IDX_P2_STATUS_B,
                                         PSR_IDX_P3_STATUS_B};
    int                    pos [6] = '{PSR_BIT_POL, PSR_BIT_TXFC, PSR_BIT_RXFC,
                                       PSR_BIT_SPEED, PSR_BIT_DUPLEX, PSR_BIT_FAULT};
    logic [31:0]           e;

    psr_regs dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .link_pol_reversed(link_pol_reversed), .link_tx_pause(link_tx_pause),
        .link_rx_pause(link_rx_pause), .link_speed_100(link_speed_100),
        .link_full_duplex(link_full_duplex), .link_remote_fault(link_remote_fault),
        .autoneg_complete(autoneg_complete), .link_good(link_good),
        .crossover_scheme_select(crossover_scheme_select),
        .coding_layer_reset(coding_layer_reset), .soft_reset_pulse(soft_reset_pulse));

    // ------------------------------------------------------------------
    // Clock, hang guard and pulse monitor
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cuts a hung handshake short; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (soft_reset_pulse === 1'b1) pulse_cnt++;
        if (cyc == 3000) begin
            bad_count++;
            $display("wrong value at %0t: run timed out", $time);
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks and compare
    // ------------------------------------------------------------------
    task automatic close_out();
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h00_0000, wd};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        r = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        chk(d, exp);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        {link_pol_reversed, link_tx_pause, link_rx_pause} = '0;
        {link_speed_100, link_full_duplex, link_remote_fault} = '0;
        {autoneg_complete, link_good} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        // Reset values of status B of ports 1 and 3, reset control and status A of port 1
        rd_chk(PSR_IDX_P1_STATUS_B, 32'h0000_0080);
        chk({30'd0, r}, 32'h0000_0000);
        rd_chk(PSR_IDX_P3_STATUS_B, 32'h0000_0000);
        rd_chk(PSR_IDX_RESET_CTRL, 32'h0000_0000);
        rd_chk(PSR_IDX_P1_STATUS_A, 32'h0000_0000);
        // Each live status kind on all ports, one kind at a time
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            link_pol_reversed <= (k == 0) ? 3'b111 : 3'b000;
            link_tx_pause     <= (k == 1) ? 3'b111 : 3'b000;
            link_rx_pause     <= (k == 2) ? 3'b111 : 3'b000;
            link_speed_100    <= (k == 3) ? 3'b111 : 3'b000;
            link_full_duplex  <= (k == 4) ? 3'b111 : 3'b000;
            link_remote_fault <= (k == 5) ? 3'b111 : 3'b000;
            repeat (8) @(posedge clk);
            for (int p = 0; p < 3; p++) begin
                e = (p < 2) ? 32'h0000_0080 : 32'h0000_0000;
                if ((k != 0 || p < 2) && (k != 5 || p == 0)) e[pos[k]] = 1'b1;
                rd_chk(idx_b[p], e);
            end
        end
        // Status A of both PHY ports
        autoneg_complete <= 2'b11;
        link_good        <= 2'b01;
        repeat (8) @(posedge clk);
        rd_chk(PSR_IDX_P1_STATUS_A, 32'h0000_0060);
        rd_chk(PSR_IDX_P2_STATUS_A, 32'h0000_0040);
        // Unmapped index answers with error code and zero data
        rd_chk(8'h50, 32'h0000_0000);
        chk({30'd0, r}, 32'h0000_0003);
        // Writes: masked byte ignored, read-only bits ignored, scheme bit cleared
        link_remote_fault <= 3'b000;
        bus(1'b1, PSR_IDX_P1_STATUS_B, 8'h00, 4'h0);
        rd_chk(PSR_IDX_P1_STATUS_B, 32'h0000_0080);
        bus(1'b1, PSR_IDX_P1_STATUS_B, 8'h7F, 4'h1);
        rd_chk(PSR_IDX_P1_STATUS_B, 32'h0000_0000);
        bus(1'b1, PSR_IDX_P2_STATUS_B, 8'hFF, 4'h1);
        rd_chk(PSR_IDX_P2_STATUS_B, 32'h0000_0080);
        bus(1'b1, PSR_IDX_P3_STATUS_B, 8'hFF, 4'h1);
        rd_chk(PSR_IDX_P3_STATUS_B, 32'h0000_0000);
        chk({30'd0, crossover_scheme_select}, 32'h0000_0002);
        // Coding layer reset alone, then with software reset
        // The control output follows the register a cycle later: look after a read
        bus(1'b1, PSR_IDX_RESET_CTRL, 8'h01, 4'h1);
        rd_chk(PSR_IDX_RESET_CTRL, 32'h0000_0001);
        chk({31'd0, coding_layer_reset}, 32'h0000_0001);
        bus(1'b1, PSR_IDX_RESET_CTRL, 8'h11, 4'h1);
        repeat (3) @(posedge clk);
        chk(pulse_cnt, 32'h0000_0001);
        chk({30'd0, crossover_scheme_select}, 32'h0000_0003);
        rd_chk(PSR_IDX_P1_STATUS_B, 32'h0000_0080);
        rd_chk(PSR_IDX_RESET_CTRL, 32'h0000_0001);
        bus(1'b1, PSR_IDX_RESET_CTRL, 8'h00, 4'h1);
        rd_chk(PSR_IDX_RESET_CTRL, 32'h0000_0000);
        chk({31'd0, coding_layer_reset}, 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire
